// ===== hdl/fifo_data_port_pkg.sv
// Constants for the aliased FIFO data port of the serial controller
package fifo_data_port_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int WORD_W = 32;
  localparam int FIELD_W = 16;
  localparam int FIELD_LSB = 0;
  localparam int FIELD_MSB = 15;
  localparam int RSVD_LSB = 16;
  localparam int RSVD_MSB = 31;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [WORD_W-1:0] word_t;
  typedef logic [FIELD_W-1:0] field_t;

  // Alias offsets held by this block
  localparam addr_t FIFO_DATA_ALIAS_27 = 8'hCC;
  localparam addr_t FIFO_DATA_ALIAS_28 = 8'hD0;
  localparam addr_t FIFO_DATA_ALIAS_29 = 8'hD4;
  localparam addr_t FIFO_DATA_ALIAS_30 = 8'hD8;
  localparam addr_t FIFO_DATA_ALIAS_31 = 8'hDC;
  localparam addr_t FIFO_DATA_ALIAS_32 = 8'hE0;
  localparam addr_t ALIAS_FIRST = FIFO_DATA_ALIAS_27;
  localparam addr_t ALIAS_LAST = FIFO_DATA_ALIAS_32;
  localparam logic [1:0] WORD_ALIGN = 2'h0;

  // Reset values
  localparam field_t FIELD_RESET = 16'h0000;
  localparam logic [RSVD_MSB-RSVD_LSB:0] RSVD_VALUE = 16'h0000;
  localparam word_t WORD_RESET = 32'h0000_0000;

  // FIFO geometry; depth is not fixed by the register map
  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int CNT_W = 4;
  typedef logic [PTR_W-1:0] ptr_t;
  typedef logic [CNT_W-1:0] cnt_t;
  localparam cnt_t CNT_FULL = 4'h8;
  localparam cnt_t CNT_ZERO = 4'h0;
  localparam ptr_t PTR_ZERO = 3'h0;

  // Channel index inside the FIFO generate loop
  localparam int CH_TX = 0;
  localparam int CH_RX = 1;
  localparam int NUM_CH = 2;

  // Frame size code is bits minus one
  localparam int FSIZE_W = 4;
  typedef logic [FSIZE_W-1:0] fsize_t;

endpackage

// ===== hdl/fifo_data_port.sv
// Aliased 16-bit data port that pushes the transmit FIFO and pops the receive FIFO
`timescale 1ns/1ps
module fifo_data_port (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Peripheral bus slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire fifo_data_port_pkg::addr_t paddr_i,
  input wire fifo_data_port_pkg::word_t pwdata_i,
  output fifo_data_port_pkg::word_t prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Controller state
  input wire logic ctrl_enable_i,
  input wire fifo_data_port_pkg::fsize_t frame_size_i,
  // Transmit FIFO drain side
  input wire logic tx_pop_i,
  output fifo_data_port_pkg::field_t tx_data_o,
  output logic tx_valid_o,
  output logic tx_full_o,
  output fifo_data_port_pkg::cnt_t tx_level_o,
  output logic tx_drop_o,
  // Receive FIFO fill side
  input wire logic rx_push_i,
  input wire fifo_data_port_pkg::field_t rx_data_i,
  output logic rx_ready_o,
  output fifo_data_port_pkg::cnt_t rx_level_o,
  output logic rx_overflow_o
);
  import fifo_data_port_pkg::*;

  // Address decode
  wire logic alias_hit;
  wire logic setup_phase;
  wire logic access_phase;
  wire logic wr_access;
  wire logic rd_setup;
  wire logic rd_access;

  assign alias_hit = (paddr_i >= ALIAS_FIRST) && (paddr_i <= ALIAS_LAST) &&
                     (paddr_i[1:0] == WORD_ALIGN);
  assign setup_phase = psel_i && !penable_i;
  assign access_phase = psel_i && penable_i;
  assign wr_access = access_phase && pwrite_i && alias_hit;
  assign rd_setup = setup_phase && !pwrite_i && alias_hit;
  assign rd_access = access_phase && !pwrite_i && alias_hit;

  // FIFO control per channel
  wire logic [NUM_CH-1:0] push;
  wire logic [NUM_CH-1:0] pop;
  field_t wdata [NUM_CH];
  field_t head [NUM_CH];
  cnt_t count [NUM_CH];
  wire logic flush;
  logic rd_valid;

  // Disable empties both FIFOs at once
  assign flush = !ctrl_enable_i;

  // Frame mask keeps only bits below the programmed frame size
  wire field_t frame_mask;
  genvar b;
  generate
    for (b = 0; b < FIELD_W; b++) begin : g_mask
      assign frame_mask[b] = (FSIZE_W'(b) <= frame_size_i);
    end
  endgenerate

  // Transmit side: written value goes in as given, upper half dropped
  assign wdata[CH_TX] = pwdata_i[FIELD_MSB:FIELD_LSB];
  assign push[CH_TX] = wr_access && ctrl_enable_i && (count[CH_TX] != CNT_FULL);
  assign pop[CH_TX] = tx_pop_i && ctrl_enable_i && (count[CH_TX] != CNT_ZERO);

  // Receive side: stale high bits of short frames are cleared on entry
  assign wdata[CH_RX] = rx_data_i & frame_mask;
  assign push[CH_RX] = rx_push_i && ctrl_enable_i && (count[CH_RX] != CNT_FULL);
  // Pop only what the setup phase captured, so a late push is never lost
  // Count guard: a flush between setup and access must not underflow
  assign pop[CH_RX] = rd_access && rd_valid && ctrl_enable_i &&
                      (count[CH_RX] != CNT_ZERO);

  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_fifo
      field_t mem [FIFO_DEPTH];
      ptr_t wr_ptr;
      ptr_t rd_ptr;
      ptr_t next_wr_ptr;
      ptr_t next_rd_ptr;
      cnt_t next_count;

      // Pointers only step or clear on flush; no entry can be addressed directly
      assign next_wr_ptr = flush ? PTR_ZERO : (push[c] ? PTR_W'(wr_ptr + 1'b1) : wr_ptr);
      assign next_rd_ptr = flush ? PTR_ZERO : (pop[c] ? PTR_W'(rd_ptr + 1'b1) : rd_ptr);
      assign next_count = flush ? CNT_ZERO :
                          CNT_W'(count[c] + {{(CNT_W-1){1'b0}}, push[c]}
                                 - {{(CNT_W-1){1'b0}}, pop[c]});
      assign head[c] = mem[rd_ptr];

      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          wr_ptr <= PTR_ZERO;
          rd_ptr <= PTR_ZERO;
          count[c] <= CNT_ZERO;
        end else begin
          wr_ptr <= next_wr_ptr;
          rd_ptr <= next_rd_ptr;
          count[c] <= next_count;
        end
      end

      // Storage needs no reset; empty entries are never presented as valid
      always_ff @(posedge clk_i) begin
        if (push[c]) begin
          mem[wr_ptr] <= wdata[c];
        end
      end
    end
  endgenerate

  // Read data is captured in setup so prdata_o comes from a flip-flop
  word_t next_prdata;
  assign next_prdata = (count[CH_RX] != CNT_ZERO) ?
                       {RSVD_VALUE, head[CH_RX]} : {RSVD_VALUE, FIELD_RESET};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= WORD_RESET;
      rd_valid <= 1'b0;
    end else if (setup_phase && !pwrite_i) begin
      prdata_o <= rd_setup ? next_prdata : WORD_RESET;
      rd_valid <= rd_setup && (count[CH_RX] != CNT_ZERO);
    end
  end

  // Event pulses for the surrounding unit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_drop_o <= 1'b0;
      rx_overflow_o <= 1'b0;
    end else begin
      tx_drop_o <= wr_access && !push[CH_TX];
      rx_overflow_o <= rx_push_i && ctrl_enable_i && !push[CH_RX];
    end
  end

  // Zero-wait slave; an unmapped offset belongs to a neighbour, so no error
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;

  assign tx_data_o = head[CH_TX];
  assign tx_valid_o = (count[CH_TX] != CNT_ZERO);
  assign tx_full_o = (count[CH_TX] == CNT_FULL);
  assign tx_level_o = count[CH_TX];
  assign rx_ready_o = ctrl_enable_i && (count[CH_RX] != CNT_FULL);
  assign rx_level_o = count[CH_RX];

  // Checks
  a_flush_empties: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ctrl_enable_i |=> (tx_level_o == CNT_ZERO) && (rx_level_o == CNT_ZERO))
    else $error("FIFO not empty after disable");

  a_write_blocked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (access_phase && pwrite_i && alias_hit && !ctrl_enable_i) |=> (tx_level_o == CNT_ZERO))
    else $error("Write pushed while disabled");

  a_write_push: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_access && ctrl_enable_i && !tx_full_o && !tx_pop_i)
    |=> (tx_level_o == $past(tx_level_o) + 1'b1))
    else $error("Write did not push");

  a_write_value: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_access && ctrl_enable_i && (tx_level_o == CNT_ZERO) && !tx_pop_i)
    |=> (tx_data_o == $past(pwdata_i[FIELD_MSB:FIELD_LSB])))
    else $error("Pushed value differs from write data");

  a_read_head: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rd_setup && (rx_level_o != CNT_ZERO))
    |=> (prdata_o[FIELD_MSB:FIELD_LSB] == $past(head[CH_RX])))
    else $error("Read data is not receive head");

  a_read_pop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rd_access && rd_valid && ctrl_enable_i && !rx_push_i && (rx_level_o != CNT_ZERO))
    |=> (rx_level_o == $past(rx_level_o) - 1'b1))
    else $error("Read did not pop one entry");

  a_upper_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (setup_phase && !pwrite_i) |=> (prdata_o[RSVD_MSB:RSVD_LSB] == RSVD_VALUE) [*2])
    else $error("Upper half not zero");

  a_rx_align: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (push[CH_RX] && (rx_level_o == CNT_ZERO) && (frame_size_i == 4'h7) && !pop[CH_RX])
    |=> (head[CH_RX][FIELD_MSB:8] == 8'h00))
    else $error("Received frame not right-aligned");

  a_no_random: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (access_phase && !pwrite_i && !alias_hit && !rx_push_i && ctrl_enable_i)
    |=> (rx_level_o == $past(rx_level_o)))
    else $error("Unmapped read touched receive FIFO");

  a_burst_beats: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_access && ctrl_enable_i && !tx_pop_i && (tx_level_o < 4'h7))
    ##1 (!tx_pop_i && ctrl_enable_i && !wr_access)
    ##1 (wr_access && ctrl_enable_i && !tx_pop_i)
    |=> (tx_level_o == $past(tx_level_o, 3) + 2'h2))
    else $error("Burst beats did not each push");

  a_reset_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rd_setup && (rx_level_o == CNT_ZERO)) |=> (prdata_o == WORD_RESET))
    else $error("Empty read not zero");

  a_ready_const: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    psel_i
    |-> pready_o)
    else $error("Bus inserted a wait state");

  a_no_error: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (psel_i && penable_i)
    |-> !pslverr_o)
    else $error("Bus reported an error");

  a_tx_drained: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (tx_pop_i && tx_valid_o && ctrl_enable_i && !wr_access && (tx_level_o == 4'h1))
    |=> !tx_valid_o)
    else $error("Transmit still valid after last pop");

  a_tx_fills: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_access && ctrl_enable_i && !tx_pop_i && (tx_level_o == 4'h7))
    |=> tx_full_o)
    else $error("Transmit not full after eighth push");

  a_full_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (tx_full_o && !tx_pop_i && ctrl_enable_i)
    |=> tx_full_o)
    else $error("Full transmit side lost an entry");

  a_rx_blocked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ctrl_enable_i
    |-> !rx_ready_o)
    else $error("Receive ready while disabled");

  a_rx_fills: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (push[CH_RX] && !pop[CH_RX] && (rx_level_o == 4'h7))
    |=> !rx_ready_o)
    else $error("Receive ready while full");

  a_drop_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_access && !ctrl_enable_i)
    |=> tx_drop_o)
    else $error("Disabled write not flagged");

  a_drop_full: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_access && tx_full_o)
    |=> tx_drop_o)
    else $error("Write to full side not flagged");

  a_drop_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !wr_access
    |=> !tx_drop_o)
    else $error("Drop flagged without a write");

  a_ovf_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rx_push_i && ctrl_enable_i && (rx_level_o == CNT_FULL))
    |=> rx_overflow_o)
    else $error("Overflow not flagged");

  a_ovf_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !rx_push_i
    |=> !rx_overflow_o)
    else $error("Overflow flagged without a push");

  a_tx_pop_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (tx_pop_i && tx_valid_o && ctrl_enable_i && !wr_access)
    |=> (tx_level_o == $past(tx_level_o) - 1'b1))
    else $error("Drain pop did not remove one entry");

  a_tx_empty_pop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (tx_pop_i && !tx_valid_o && !wr_access)
    |=> (tx_level_o == CNT_ZERO))
    else $error("Pop of empty transmit side moved it");

  a_prdata_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(setup_phase && !pwrite_i)
    |=> $stable(prdata_o))
    else $error("Read data changed outside read setup");

  a_unmapped_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (setup_phase && !pwrite_i && !alias_hit)
    |=> (prdata_o == WORD_RESET))
    else $error("Unmapped read not zero");

  a_rx_no_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (access_phase && pwrite_i && !rx_push_i && ctrl_enable_i)
    |=> (rx_level_o == $past(rx_level_o)))
    else $error("Write touched receive side");

  a_tx_no_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (access_phase && !pwrite_i && !tx_pop_i && ctrl_enable_i)
    |=> (tx_level_o == $past(tx_level_o)))
    else $error("Read touched transmit side");

  a_rx_push_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rx_push_i && rx_ready_o && !rd_access)
    |=> (rx_level_o == $past(rx_level_o) + 1'b1))
    else $error("Fill push did not add one entry");

  a_empty_no_pop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rd_access && (rx_level_o == CNT_ZERO) && !rx_push_i)
    |=> (rx_level_o == CNT_ZERO))
    else $error("Read of empty side moved it");

  a_capture_valid: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rd_setup && (rx_level_o != CNT_ZERO))
    |=> rd_valid)
    else $error("Nonempty read not marked for pop");

  a_capture_empty: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rd_setup && (rx_level_o == CNT_ZERO))
    |=> !rd_valid)
    else $error("Empty read marked for pop");

  a_rx_full_width: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (push[CH_RX] && (rx_level_o == CNT_ZERO) && !pop[CH_RX] && (frame_size_i == 4'hF))
    |=> (head[CH_RX] == $past(rx_data_i)))
    else $error("Sixteen-bit frame altered on entry");

endmodule

// ===== dv/fifo_bus_master.sv
// Bus master model that drives setup and access cycles at the data port
`timescale 1ns/1ps
module fifo_bus_master
  import fifo_data_port_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Bus request
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output addr_t paddr_o,
  output word_t pwdata_o,
  // Bus answer
  input wire word_t prdata_i,
  input wire logic pready_i
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0000_0000;
  end

  // Request held until the edge that samples ready, then released
  // keep leaves select up so the next call runs back to back, as a burst does
  task automatic xfer(input logic wr, input addr_t a, input word_t d, input logic keep,
                      output word_t q);
    @(negedge clk_i);
    psel_o = 1'b1;
    penable_o = 1'b0;
    pwrite_o = wr;
    paddr_o = a;
    pwdata_o = d;
    @(negedge clk_i);
    penable_o = 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 16 && pready_i !== 1'b1; i++) @(posedge clk_i);
    q = prdata_i;
    if (!keep) begin
      @(negedge clk_i);
      psel_o = 1'b0;
      penable_o = 1'b0;
      // Released lines do not keep the last value
      paddr_o = ~a;
      pwdata_o = ~d;
    end
  endtask
endmodule

// ===== dv/fifo_data_port_tb_top.sv
// Self-checking bench for the aliased FIFO data port
`timescale 1ns/1ps
module fifo_data_port_tb_top;
  import fifo_data_port_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, en, tx_pop, tx_valid, tx_full, tx_drop;
  logic rx_push, rx_ready, rx_ovf;
  addr_t paddr;
  word_t pwdata, prdata, q;
  fsize_t fsize;
  field_t tx_data, rx_data;
  cnt_t tx_level, rx_level;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;

  always #25 clk = ~clk;

  fifo_bus_master bus_u (.clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready));
  fifo_data_port dut_u (.clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .ctrl_enable_i(en), .frame_size_i(fsize),
    .tx_pop_i(tx_pop), .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_full_o(tx_full),
    .tx_level_o(tx_level), .tx_drop_o(tx_drop), .rx_push_i(rx_push), .rx_data_i(rx_data),
    .rx_ready_o(rx_ready), .rx_level_o(rx_level), .rx_overflow_o(rx_ovf));

  task automatic chk_w(input string n, input word_t e, input word_t g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_f(input string n, input field_t e, input field_t g);
    chk_w(n, {16'h0000, e}, {16'h0000, g});
  endtask
  task automatic chk_c(input string n, input cnt_t e, input cnt_t g);
    chk_w(n, {28'h0000000, e}, {28'h0000000, g});
  endtask

  task automatic chk_b(input string n, input logic e, input logic g);
    chk_w(n, {31'h0000_0000, e}, {31'h0000_0000, g});
  endtask

  task automatic rd(input addr_t a, input logic keep, input word_t e);
    bus_u.xfer(1'b0, a, 32'h0000_0000, keep, q);
    chk_w("prdata", e, q);
  endtask
  task automatic push_rx(input field_t d);
    @(negedge clk);
    rx_push = 1'b1;
    rx_data = d;
    @(negedge clk);
    rx_push = 1'b0;
    rx_data = ~d;
  endtask
  task automatic pop_tx();
    @(negedge clk);
    tx_pop = 1'b1;
    @(negedge clk);
    tx_pop = 1'b0;
  endtask

  task automatic t_reset();
    rd(ALIAS_FIRST, 1'b0, WORD_RESET);
    chk_c("rx_level", CNT_ZERO, rx_level);
    chk_b("tx_valid", 1'b0, tx_valid);
    chk_b("rx_ready", 1'b0, rx_ready);
    chk_b("pready", 1'b1, pready);
    chk_b("pslverr", 1'b0, pslverr);
  endtask
  // Burst over every alias, upper half filled with junk that must vanish
  task automatic t_tx();
    en = 1'b1;
    for (int i = 0; i < 6; i++)
      bus_u.xfer(1'b1, ALIAS_FIRST + addr_t'(4 * i), {16'hDEAD, 16'h1000 + 16'(i)}, i < 5, q);
    chk_c("tx_level", 4'h6, tx_level);
    for (int i = 0; i < 6; i++) begin
      chk_f("tx_data", 16'h1000 + 16'(i), tx_data);
      pop_tx();
    end
    chk_c("tx_level", CNT_ZERO, tx_level);
  endtask
  // Eight-bit frames must read back with high bits cleared
  task automatic t_rx();
    fsize = 4'h7;
    for (int i = 0; i < 6; i++) push_rx(16'hA5C0 + 16'(i));
    chk_c("rx_level", 4'h6, rx_level);
    for (int i = 0; i < 6; i++)
      rd(ALIAS_FIRST + addr_t'(4 * i), i < 5, 32'h0000_00C0 + 32'(i));
    chk_c("rx_level", CNT_ZERO, rx_level);
  endtask
  task automatic t_off();
    bus_u.xfer(1'b1, ALIAS_LAST, 32'h0000_0055, 1'b0, q);
    push_rx(16'h0033);
    chk_c("tx_level", 4'h1, tx_level);
    @(negedge clk);
    en = 1'b0;
    @(negedge clk);
    chk_c("tx_level", CNT_ZERO, tx_level);
    chk_c("rx_level", CNT_ZERO, rx_level);
    bus_u.xfer(1'b1, FIFO_DATA_ALIAS_29, 32'h0000_0077, 1'b0, q);
    chk_b("tx_drop", 1'b1, tx_drop);
    en = 1'b1;
    @(negedge clk);
    chk_c("tx_level", CNT_ZERO, tx_level);
  endtask
  // Fill both sides to the brim; one more of each must be refused
  task automatic t_full();
    fsize = 4'hF;
    for (int i = 0; i < 8; i++)
      bus_u.xfer(1'b1, FIFO_DATA_ALIAS_30, 32'h0000_2000 + 32'(i), i < 7, q);
    chk_b("tx_full", 1'b1, tx_full);
    chk_b("tx_valid", 1'b1, tx_valid);
    bus_u.xfer(1'b1, FIFO_DATA_ALIAS_31, 32'h0000_2FFF, 1'b0, q);
    chk_b("tx_drop", 1'b1, tx_drop);
    chk_c("tx_level", CNT_FULL, tx_level);
    chk_f("tx_data", 16'h2000, tx_data);
    for (int i = 0; i < 8; i++) push_rx(16'hF000 + 16'(i));
    chk_b("rx_ready", 1'b0, rx_ready);
    push_rx(16'hFFFF);
    chk_b("rx_overflow", 1'b1, rx_ovf);
    rd(8'hC8, 1'b0, WORD_RESET);
    rd(8'hCD, 1'b0, WORD_RESET);
    rd(8'hE4, 1'b0, WORD_RESET);
    chk_c("rx_level", CNT_FULL, rx_level);
    rd(FIFO_DATA_ALIAS_28, 1'b0, 32'h0000_F000);
    chk_c("rx_level", 4'h7, rx_level);
    chk_b("pslverr", 1'b0, pslverr);
    @(negedge clk);
    en = 1'b0;
    @(negedge clk);
    chk_c("tx_level", CNT_ZERO, tx_level);
    chk_c("rx_level", CNT_ZERO, rx_level);
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    en = 1'b0;
    fsize = 4'hF;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_data = 16'h0000;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_off();
    t_full();
    stop_test();
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      stop_test();
    end
  end
endmodule
